// ### hdl/mrg_cfg.svh
// timing constants for the manual reset release gate
`ifndef MRG_CFG_SVH
`define MRG_CFG_SVH
`define MRG_CYC_PER_MS      40000
`define MRG_MIN_SHORT_MS    100
`define MRG_MIN_LONG_MS     350
`define MRG_MAX_PULSE_MS    30000
`define MRG_FLASH_HALF_MS   500
`define MRG_MS_TO_CYC(ms)   ((ms) * `MRG_CYC_PER_MS)
`define MRG_NUM_INPUTS      8
`define MRG_RST_RELEASE     1'b0
`define MRG_RST_REQ         1'b0
`define MRG_RST_COND        1'b0
`endif

// ### hdl/mrg_pkg.sv
// types for the manual reset release gate
package mrg_pkg;
    typedef enum logic [0:0] {
        MRG_ST_LOCKED   = 1'b0,
        MRG_ST_RELEASED = 1'b1
    } mrg_state_type;
    typedef enum logic [0:0] {
        MRG_MIN_SHORT = 1'b0,
        MRG_MIN_LONG  = 1'b1
    } mrg_minsel_type;
endpackage

// ### hdl/mrg_sync3.sv
// three-stage pin synchroniser, change taken when stages two and three agree
`timescale 1ns/10ps
module mrg_sync3 #(
    parameter logic RST_VAL = 1'b0
) (
    input  wire logic i_clk,
    input  wire logic i_rst,
    input  wire logic i_d,
    output logic      o_q
);
    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic q_q;
    logic q_d;

    // accept a level only once two late stages match, filters one-cycle glitches
    assign q_d = (s2_q == s3_q) ? s3_q : q_q;
    assign o_q = q_q;

    // first stage feeds only the second
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            s1_q <= RST_VAL;
            s2_q <= RST_VAL;
            s3_q <= RST_VAL;
            q_q  <= RST_VAL;
        end else begin
            s1_q <= i_d;
            s2_q <= s1_q;
            s3_q <= s2_q;
            q_q  <= q_d;
        end
    end
endmodule

// ### hdl/mrg_gate.sv
// manual reset / restart release gate: acknowledge pulse check, flashing request, release output
// Functional notes
// - minimum acknowledge pulse selectable, 100 or 350 ms
// - ignore pulses too short or over 30 s
// - two to eight inputs, one to seven release
// - condition output is AND of enabled inputs
// - request flashes 1 Hz while awaiting acknowledge
// - release rises after condition and valid acknowledge
// - any release input low drops release
// - restart variant is this same logic
`timescale 1ns/10ps
`include "mrg_cfg.svh"
module mrg_gate #(
    parameter int NUM_INPUTS    = `MRG_NUM_INPUTS,
    parameter int MIN_SHORT_CYC = `MRG_MS_TO_CYC(`MRG_MIN_SHORT_MS),
    parameter int MIN_LONG_CYC  = `MRG_MS_TO_CYC(`MRG_MIN_LONG_MS),
    parameter int MAX_PULSE_CYC = `MRG_MS_TO_CYC(`MRG_MAX_PULSE_MS),
    parameter int FLASH_CYC     = `MRG_MS_TO_CYC(`MRG_FLASH_HALF_MS)
) (
    input  wire logic                   I_MCLK,
    input  wire logic                   I_RST,
    input  wire logic                   I_RUN,
    input  wire mrg_pkg::mrg_minsel_type I_MIN_SEL,
    input  wire logic                   I_ACK,
    input  wire logic [NUM_INPUTS-2:0]  I_REL_IN,
    output logic                        O_COND,
    output logic                        O_REQ,
    output logic                        O_RELEASE
);
    import mrg_pkg::*;

    localparam int NREL = NUM_INPUTS - 1;
    localparam int CW   = $clog2(MAX_PULSE_CYC + 2);
    localparam int FW   = $clog2(FLASH_CYC + 1);

    // elaboration checks: refuse settings the counters and the input vector cannot serve
    if (NUM_INPUTS < 2 || NUM_INPUTS > 8) begin : g_bad_inputs
        $error("mrg_gate: NUM_INPUTS must be 2 to 8");
    end
    if (MIN_SHORT_CYC < 1 || MIN_LONG_CYC < MIN_SHORT_CYC) begin : g_bad_min
        $error("mrg_gate: minimum pulse settings inconsistent");
    end
    if (MAX_PULSE_CYC <= MIN_LONG_CYC) begin : g_bad_max
        $error("mrg_gate: maximum pulse must exceed both minimums");
    end
    if (MAX_PULSE_CYC > 32'h7ffffffd) begin : g_bad_range
        $error("mrg_gate: maximum pulse too large for the length counter");
    end
    if (FLASH_CYC < 1) begin : g_bad_flash
        $error("mrg_gate: FLASH_CYC must be at least 1");
    end

    // synchronised pins
    logic               ack_s;
    logic [NREL-1:0]    rel_s;
    // acknowledge pulse measurement
    logic               ack_prev_q;
    logic               ack_rise;
    logic               ack_fall;
    logic [CW-1:0]      len_q;
    logic [CW-1:0]      len_d;
    logic [CW-1:0]      min_cyc;
    logic [CW-1:0]      max_cyc;
    logic [CW-1:0]      sat_cyc;
    logic               len_ok;
    logic               ack_valid;
    logic               stale_q;
    logic               stale_d;
    mrg_minsel_type     minsel_q;
    // run tracking and release condition
    logic               run_q;
    logic               active;
    logic               cond_w;
    logic               cond_q;
    // request flash
    logic               waiting;
    logic               flash_wrap;
    logic [FW-1:0]      flash_q;
    logic [FW-1:0]      flash_d;
    logic               req_q;
    logic               req_d;
    // release state and its output register
    mrg_state_type      state_q;
    mrg_state_type      state_d;
    logic               rel_q;
    logic               rel_d;

    // pins come from outside the clock domain
    mrg_sync3 #(
        .RST_VAL (1'b0)
    ) u_sync_ack (
        .i_clk (I_MCLK),
        .i_rst (I_RST),
        .i_d   (I_ACK),
        .o_q   (ack_s)
    );

    // one synchroniser per enabled release input
    genvar gi;
    generate
        for (gi = 0; gi < NREL; gi++) begin : g_rel
            mrg_sync3 #(
                .RST_VAL (1'b0)
            ) u_sync_rel (
                .i_clk (I_MCLK),
                .i_rst (I_RST),
                .i_d   (I_REL_IN[gi]),
                .o_q   (rel_s[gi])
            );
        end
    endgenerate

    // condition and pulse decoding
    assign cond_w    = &rel_s;
    assign ack_rise  = ack_s && !ack_prev_q;
    assign ack_fall  = !ack_s && ack_prev_q;
    assign min_cyc   = (minsel_q == MRG_MIN_LONG) ? CW'(MIN_LONG_CYC)
                                                  : CW'(MIN_SHORT_CYC);
    assign max_cyc   = CW'(MAX_PULSE_CYC);
    assign sat_cyc   = CW'(MAX_PULSE_CYC + 1);
    assign len_ok    = (len_q >= min_cyc) && (len_q <= max_cyc);
    assign ack_valid = ack_fall && len_ok && !stale_q;
    assign active    = I_RUN && run_q;                            // one idle cycle after stop to run

    // pulse length counter saturates just past the maximum, so an overlong press stays invalid
    assign len_d = ack_rise ? CW'(1) :
                   (ack_s && len_q != sat_cyc) ? len_q + CW'(1) : len_q;

    // a press that began during stop is not trusted after the run transition
    assign stale_d = !active ? ack_s : (ack_rise ? 1'b0 : stale_q);

    // release state: one valid acknowledge arms it, any falling input drops it
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            MRG_ST_LOCKED: begin
                if (active && cond_w && ack_valid) begin
                    state_d = MRG_ST_RELEASED;
                end
            end
            MRG_ST_RELEASED: begin
                if (!active || !cond_w) begin
                    state_d = MRG_ST_LOCKED;
                end
            end
        endcase
    end

    // request flash: toggles every half second while waiting, 1 Hz period
    assign waiting    = active && cond_w && (state_d == MRG_ST_LOCKED);
    assign flash_wrap = (flash_q == FW'(FLASH_CYC - 1));
    assign flash_d    = (!waiting || flash_wrap) ? '0 : flash_q + FW'(1);
    assign req_d      = !waiting ? 1'b0 : (flash_wrap ? !req_q : req_q);
    assign rel_d      = (state_d == MRG_ST_RELEASED);

    // edge history and pulse length; idle level of the button is low, so no false edge after reset
    always_ff @(posedge I_MCLK) begin
        if (I_RST) begin
            ack_prev_q <= 1'b0;
            len_q      <= '0;
            stale_q    <= 1'b0;
        end else begin
            ack_prev_q <= ack_s;
            len_q      <= len_d;
            stale_q    <= stale_d;
        end
    end

    // run tracking: the first cycle after stop to run is treated as still stopped
    always_ff @(posedge I_MCLK) begin
        if (I_RST) begin
            run_q <= 1'b0;
        end else begin
            run_q <= I_RUN;
        end
    end

    // minimum pulse setting is registered from the configuration input on every clock after reset
    always_ff @(posedge I_MCLK) begin
        if (I_RST) begin
            minsel_q <= MRG_MIN_SHORT;
        end else begin
            minsel_q <= I_MIN_SEL;
        end
    end

    // release state; the same logic serves reset and restart use
    always_ff @(posedge I_MCLK) begin
        if (I_RST) begin
            state_q <= MRG_ST_LOCKED;
        end else begin
            state_q <= state_d;
        end
    end

    // release output register mirrors the state so the pin comes straight from a flop
    always_ff @(posedge I_MCLK) begin
        if (I_RST) begin
            rel_q <= `MRG_RST_RELEASE;
        end else begin
            rel_q <= rel_d;
        end
    end

    // condition output register
    always_ff @(posedge I_MCLK) begin
        if (I_RST) begin
            cond_q <= `MRG_RST_COND;
        end else begin
            cond_q <= cond_w;
        end
    end

    // request flash counter and lamp output
    always_ff @(posedge I_MCLK) begin
        if (I_RST) begin
            req_q   <= `MRG_RST_REQ;
            flash_q <= '0;
        end else begin
            req_q   <= req_d;
            flash_q <= flash_d;
        end
    end

    assign O_COND    = cond_q;
    assign O_REQ     = req_q;
    assign O_RELEASE = rel_q;
endmodule

// ### dv/mrg_gate_chk.sv
// port assertions for the release gate
`timescale 1ns/10ps
module mrg_gate_chk #(
    parameter int NUM_INPUTS = 8
) (
    input wire logic                    I_MCLK,
    input wire logic                    I_RST,
    input wire logic                    I_RUN,
    input wire mrg_pkg::mrg_minsel_type I_MIN_SEL,
    input wire logic                    I_ACK,
    input wire logic [NUM_INPUTS-2:0]   I_REL_IN,
    input wire logic                    O_COND,
    input wire logic                    O_REQ,
    input wire logic                    O_RELEASE
);
    import mrg_pkg::*;
    default clocking cb @(posedge I_MCLK); endclocking
    default disable iff (I_RST);
    // six cycles covers the synchroniser plus the output register
    cond_and_high_a: assert property ((&I_REL_IN) [*6] |-> O_COND)
        else $error("cond low with all inputs high");
    cond_and_low_a: assert property ((!(&I_REL_IN)) [*6] |-> !O_COND)
        else $error("cond high with an input low");
    rel_needs_cond_a: assert property ($rose(O_RELEASE) |-> O_COND)
        else $error("release without cond");
    rel_after_ack_a: assert property ($rose(O_RELEASE) |-> $past(I_ACK, 6) && !$past(I_ACK, 5))
        else $error("release without a press");
    rel_drop_a: assert property (O_RELEASE && !(&I_REL_IN) |-> ##[1:6] !O_RELEASE)
        else $error("release kept with input low");
    stop_hold_a: assert property (!I_RUN |=> !O_RELEASE)
        else $error("release while stopped");
    // the flash only runs while the controller is in run
    req_flash_a: assert property (I_RUN && O_COND && !O_RELEASE && !O_REQ
        |-> ##[1:10] (O_REQ || !O_COND || O_RELEASE || !I_RUN))
        else $error("request not flashing");
    req_quiet_a: assert property (O_RELEASE |-> !O_REQ)
        else $error("request while released");
endmodule
bind mrg_gate mrg_gate_chk #(.NUM_INPUTS(NUM_INPUTS)) mrg_gate_chk_inst (.I_MCLK, .I_RST, .I_RUN, .I_MIN_SEL,
    .I_ACK, .I_REL_IN, .O_COND, .O_REQ, .O_RELEASE);

// ### dv/mrg_btn_model.sv
// acknowledge pushbutton model, held for a requested number of cycles
`timescale 1ns/10ps
module mrg_btn_model (
    input  wire logic        i_clk,
    input  wire logic        i_go,
    input  wire logic [31:0] i_len,
    output logic             o_ack
);
    int cnt_q = 0;
    // clean press, no contact bounce: a limitation of this model
    always_ff @(posedge i_clk) begin
        if (i_go && cnt_q == 0)
            cnt_q <= i_len;
        else if (cnt_q > 0)
            cnt_q <= cnt_q - 1;
    end
    assign o_ack = (cnt_q > 0);
endmodule

// ### dv/test_mrg_gate.sv
// self-checking bench for the release gate
`timescale 1ns/10ps
module test_mrg_gate;
    import mrg_pkg::*;
    logic           clk = 1'b0;
    logic           rst = 1'b1;
    logic           run = 1'b0;
    logic           go  = 1'b0;
    logic [2:0]     rel = 3'h0;
    mrg_minsel_type sel = MRG_MIN_SHORT;
    logic           ack, cond, req, rel_out;
    int             len = 0, mismatches = 0, n_compared = 0, seed = 24, k;
    int             lens[6] = '{9, 10, 100, 101, 19, 20};
    logic [5:0]     sel_bits = 6'h30;
    // short counts keep the run small
    mrg_gate #(.NUM_INPUTS(4), .MIN_SHORT_CYC(10), .MIN_LONG_CYC(20), .MAX_PULSE_CYC(100), .FLASH_CYC(8))
        mrg_gate_inst (.I_MCLK(clk), .I_RST(rst), .I_RUN(run), .I_MIN_SEL(sel), .I_ACK(ack),
        .I_REL_IN(rel), .O_COND(cond), .O_REQ(req), .O_RELEASE(rel_out));
    mrg_btn_model mrg_btn_model_inst (.i_clk(clk), .i_go(go), .i_len(len), .o_ack(ack));
    initial forever #12.5 clk = ~clk;
    function automatic logic valid_len(input mrg_minsel_type s, input int n);
        return n >= (s == MRG_MIN_LONG ? 20 : 10) && n <= 100;
    endfunction
    task automatic chk(input logic got, input logic exp, input string msg);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask
    // one press, then release is judged well after the falling edge
    task automatic press(input mrg_minsel_type s, input int n);
        @(posedge clk);
        sel <= s;
        len <= n;
        go  <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        repeat (n + 12) @(posedge clk);
        #1;
        chk(rel_out, valid_len(s, n), "release after press");
    endtask
    // drop one input at random, then restore: a fresh press is then needed
    task automatic clear;
        @(posedge clk);
        rel <= ~(3'h1 << ($unsigned($random(seed)) % 3));
        repeat (8) @(posedge clk);
        #1;
        chk(rel_out, 1'b0, "release kept");
        chk(cond, 1'b0, "cond with input low");
        @(posedge clk);
        rel <= 3'h7;
        repeat (8) @(posedge clk);
        #1;
        chk(rel_out, 1'b0, "release without press");
        $display("test done at %0t", $time);
    endtask
    task automatic finish_test;
        $display("compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        #(25 * 20000);
        mismatches++;
        finish_test();
    end
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        run <= 1'b1;
        rel <= 3'h7;
        repeat (10) @(posedge clk);
        #1;
        chk(cond, 1'b1, "cond");
        chk(rel_out, 1'b0, "release after start");
        k = 0;
        repeat (20) begin
            @(posedge clk);
            #1;
            k += req;
        end
        chk(k > 0 && k < 20, 1'b1, "request flashing");
        $display("test done at %0t", $time);
        foreach (lens[i]) begin
            press(mrg_minsel_type'(sel_bits[i]), lens[i]);
            clear();
        end
        repeat (6) begin
            press(mrg_minsel_type'(1'($random(seed))), 5 + $unsigned($random(seed)) % 110);
            clear();
        end
        press(MRG_MIN_SHORT, 30);
        @(posedge clk);
        run <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        chk(rel_out, 1'b0, "release while stopped");
        @(posedge clk);
        run <= 1'b1;
        repeat (10) @(posedge clk);
        #1;
        chk(rel_out, 1'b0, "release after restart");
        // a press begun while stopped must not count once running again
        @(posedge clk);
        run <= 1'b0;
        len <= 30;
        go  <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        repeat (8) @(posedge clk);
        run <= 1'b1;
        repeat (40) @(posedge clk);
        #1;
        chk(rel_out, 1'b0, "press from stop accepted");
        $display("test done at %0t", $time);
        press(MRG_MIN_LONG, 25);
        finish_test();
    end
endmodule
